// ### logic/bmc_misc_config.sv
/*
  Miscellaneous host configuration register, low eleven bits, with the
  control effects those bits have on events, reads and clock gating.
  Assumes configuration accesses arrive synchronous to CLK_SYS, one per
  cycle, and that the fundamental reset inputs are already synchronous.
*/
// Overview of operation
// - Override bit mirrors into vendor ID bit 26
// - Override decides whether master enable gates events
// - One or two phase reads use plain read
// - Field picks long read command; 11 acts default
// - Version select reports 010b or 011b; resets one
// - Bits 6 and 5 ignore writes, read zero
// - Unclocked link access: abort, or all ones data
// - No-abort bit resets to one
// - Serial bus enable bit stores only, resets zero
// - Bit 2 disables automatic PHY clock gating
// - Bit 1 disables automatic host clock gating
// - Keep-clock bit stores only, resets zero
// - Fields except override reset on any fundamental reset
// - Low global reset or link reset forces fundamental reset
`timescale 1ns/1ps
module bmc_misc_config (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire GLOBAL_RESET_INPUT_N,
  input wire LINK_FUND_RESET_N,
  input wire CFG_SEL,
  input wire CFG_WR,
  input wire [7:0] CFG_ADDR,
  input wire [3:0] CFG_BYTE_EN,
  input wire [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVALID,
  input wire VID_READ_IN,
  output logic VID_BIT26,
  output logic [2:0] PM_VERSION,
  input wire INT_PENDING_UNMASKED,
  input wire MASTER_INTERRUPT_ENABLE,
  output logic PM_EVENT,
  input wire LINK_ACC,
  input wire LINK_CLK_ACTIVE,
  output logic LINK_TARGET_ABORT,
  output logic LINK_DATA_FORCE,
  output logic [31:0] LINK_FORCE_DATA,
  input wire MST_RD_REQ,
  input wire [3:0] MST_RD_PHASES,
  output logic [1:0] MST_RD_CMD,
  output logic PHY_AUTO_GATE_EN,
  output logic HOST_AUTO_GATE_EN,
  output logic SERIAL_BUS_ENABLE_UNUSED,
  output logic KEEP_CLOCK_UNUSED
);
  typedef struct packed {
    bmc_pkg::bmc_fields_t fld;
    logic [31:0] rdata;
    logic rvalid;
    logic vid26;
    logic [2:0] pmver;
    logic pm_event;
    logic abort;
    logic force_data;
    logic [1:0] rd_cmd;
    logic phy_gate;
    logic host_gate;
  } bmc_state_t;

  bmc_state_t st_ff;
  bmc_state_t nxt_st;
  bmc_pkg::bmc_cfg_req_t req;
  bmc_pkg::bmc_cmd_t sel_cmd;
  logic fund_rst;
  logic [10:0] low_bits;
  logic [31:0] wmask;

  assign req = '{sel: CFG_SEL, wr: CFG_WR, byte_en: CFG_BYTE_EN,
                 wdata: CFG_WDATA};

  // Either low fundamental input or the power-on reset loads the bank reset values; only the power-on reset loads the override
  assign fund_rst = SYS_RST | ~GLOBAL_RESET_INPUT_N
                  | ~LINK_FUND_RESET_N;

  bmc_cmd_sel i_bmc_cmd_sel (
    .rdsel(st_ff.fld.read_command_select),
    .phases(MST_RD_PHASES),
    .cmd(sel_cmd)
  );

  always_comb begin
    low_bits = '0;
    low_bits[bmc_pkg::OVERRIDE_POS] = st_ff.fld.power_event_interrupt_override;
    low_bits[bmc_pkg::RDSEL_LSB +: 2] = st_ff.fld.read_command_select;
    low_bits[bmc_pkg::PMVER_POS] = st_ff.fld.pm_version_select;
    low_bits[bmc_pkg::NOABORT_POS] = st_ff.fld.no_abort_mode;
    low_bits[bmc_pkg::SBEN_POS] = st_ff.fld.serial_bus_enable_unused;
    low_bits[bmc_pkg::PHYGATE_POS] = st_ff.fld.phy_clock_gate_disable;
    low_bits[bmc_pkg::HOSTGATE_POS] = st_ff.fld.host_clock_gate_disable;
    low_bits[bmc_pkg::KEEPCLK_POS] = st_ff.fld.keep_clock_unused;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{req.byte_en[gi]}};
    end
  endgenerate

  always_comb begin
    logic [31:0] cur;
    logic [31:0] upd;
    cur = 32'h0000_0000;
    upd = 32'h0000_0000;
    nxt_st = st_ff;
    cur[10:0] = low_bits;
    upd = (cur & ~wmask) | (req.wdata & wmask);
    // Reserved bits never store anything, so a masked merge is enough
    if (req.sel && req.wr && CFG_ADDR == bmc_pkg::MISC_HOST_CONFIG_OFS) begin
      upd[10:0] = upd[10:0] & bmc_pkg::LOW_WRITE_MASK;
      nxt_st.fld.power_event_interrupt_override = upd[bmc_pkg::OVERRIDE_POS];
      nxt_st.fld.read_command_select =
        bmc_pkg::bmc_rdsel_t'(upd[bmc_pkg::RDSEL_LSB +: 2]);
      nxt_st.fld.pm_version_select = upd[bmc_pkg::PMVER_POS];
      nxt_st.fld.no_abort_mode = upd[bmc_pkg::NOABORT_POS];
      nxt_st.fld.serial_bus_enable_unused = upd[bmc_pkg::SBEN_POS];
      nxt_st.fld.phy_clock_gate_disable = upd[bmc_pkg::PHYGATE_POS];
      nxt_st.fld.host_clock_gate_disable = upd[bmc_pkg::HOSTGATE_POS];
      nxt_st.fld.keep_clock_unused = upd[bmc_pkg::KEEPCLK_POS];
    end
    nxt_st.rvalid = req.sel && !req.wr;
    nxt_st.rdata = 32'h0000_0000;
    if (req.sel && !req.wr && CFG_ADDR == bmc_pkg::MISC_HOST_CONFIG_OFS) begin
      // Upper fixed bits keep their constant value; bits 6:5 stay zero
      nxt_st.rdata = bmc_pkg::UPPER_READ_VALUE | cur;
    end
    nxt_st.vid26 = VID_READ_IN
                 & nxt_st.fld.power_event_interrupt_override;
    nxt_st.pmver = nxt_st.fld.pm_version_select ? bmc_pkg::PM_VERSION_12
                 : bmc_pkg::PM_VERSION_11;
    // Override drops the master enable from the event path
    nxt_st.pm_event = INT_PENDING_UNMASKED
      & (MASTER_INTERRUPT_ENABLE
         | st_ff.fld.power_event_interrupt_override);
    nxt_st.abort = LINK_ACC & !LINK_CLK_ACTIVE
                 & !st_ff.fld.no_abort_mode;
    nxt_st.force_data = LINK_ACC & !LINK_CLK_ACTIVE
                      & st_ff.fld.no_abort_mode;
    nxt_st.rd_cmd = MST_RD_REQ ? 2'(sel_cmd) : st_ff.rd_cmd;
    nxt_st.phy_gate = !st_ff.fld.phy_clock_gate_disable;
    nxt_st.host_gate = !st_ff.fld.host_clock_gate_disable;
  end

  always_ff @(posedge CLK_SYS) begin
    if (fund_rst) begin
      // Override keeps its value across global and link reset; SYS_RST loads OVERRIDE_RESET
      st_ff <= '0;
      st_ff.fld.power_event_interrupt_override <=
        SYS_RST ? bmc_pkg::OVERRIDE_RESET
                : st_ff.fld.power_event_interrupt_override;
      st_ff.fld.read_command_select <=
        bmc_pkg::bmc_rdsel_t'(bmc_pkg::RDSEL_RESET);
      st_ff.fld.pm_version_select <= bmc_pkg::PMVER_RESET;
      st_ff.fld.no_abort_mode <= bmc_pkg::NOABORT_RESET;
      st_ff.pmver <= bmc_pkg::PM_VERSION_12;
      st_ff.phy_gate <= 1'b1;
      st_ff.host_gate <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign CFG_RDATA = st_ff.rdata;
  assign CFG_RVALID = st_ff.rvalid;
  assign VID_BIT26 = st_ff.vid26;
  assign PM_VERSION = st_ff.pmver;
  assign PM_EVENT = st_ff.pm_event;
  assign LINK_TARGET_ABORT = st_ff.abort;
  assign LINK_DATA_FORCE = st_ff.force_data;
  assign LINK_FORCE_DATA = bmc_pkg::ALL_ONES;
  assign MST_RD_CMD = st_ff.rd_cmd;
  assign PHY_AUTO_GATE_EN = st_ff.phy_gate;
  assign HOST_AUTO_GATE_EN = st_ff.host_gate;
  assign SERIAL_BUS_ENABLE_UNUSED = st_ff.fld.serial_bus_enable_unused;
  assign KEEP_CLOCK_UNUSED = st_ff.fld.keep_clock_unused;
endmodule : bmc_misc_config

// ### logic/bmc_pkg.sv
/*
  Package for the miscellaneous host configuration register bank:
  offsets, field positions, reset values and the carried structs.
  Assumes a 32-bit configuration access path with byte enables.
*/
package bmc_pkg;
  localparam logic [7:0] MISC_HOST_CONFIG_OFS = 8'hf0;
  localparam int OVERRIDE_POS = 10;
  localparam int RDSEL_LSB = 8;
  localparam int PMVER_POS = 7;
  localparam int NOABORT_POS = 4;
  localparam int SBEN_POS = 3;
  localparam int PHYGATE_POS = 2;
  localparam int HOSTGATE_POS = 1;
  localparam int KEEPCLK_POS = 0;
  localparam int VID_OVERRIDE_POS = 26;
  localparam logic [10:0] LOW_WRITE_MASK = 11'h79f;
  localparam logic [31:0] UPPER_READ_VALUE = 32'h0000_0800;

  typedef enum logic [1:0] {
    BMC_RD_LINE = 2'b00,
    BMC_RD_PLAIN = 2'b01,
    BMC_RD_MULTI = 2'b10,
    BMC_RD_RSVD = 2'b11
  } bmc_rdsel_t;

  typedef enum logic [1:0] {
    BMC_CMD_READ = 2'b00,
    BMC_CMD_READ_LINE = 2'b01,
    BMC_CMD_READ_MULTI = 2'b10
  } bmc_cmd_t;

  localparam logic [1:0] RDSEL_RESET = 2'b10;
  localparam logic PMVER_RESET = 1'b1;
  localparam logic NOABORT_RESET = 1'b1;
  localparam logic OVERRIDE_RESET = 1'b0;
  localparam logic [2:0] PM_VERSION_11 = 3'h2;
  localparam logic [2:0] PM_VERSION_12 = 3'h3;
  localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
  localparam logic [3:0] SHORT_READ_PHASES = 4'h2;

  typedef struct packed {
    logic power_event_interrupt_override;
    bmc_rdsel_t read_command_select;
    logic pm_version_select;
    logic no_abort_mode;
    logic serial_bus_enable_unused;
    logic phy_clock_gate_disable;
    logic host_clock_gate_disable;
    logic keep_clock_unused;
  } bmc_fields_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } bmc_cfg_req_t;
endpackage : bmc_pkg

// ### logic/bmc_cmd_sel.sv
/*
  Read command chooser for the bus master.
  Assumes the phase count is valid whenever a request is presented.
*/
`timescale 1ns/1ps
module bmc_cmd_sel (
  input wire [1:0] rdsel,
  input wire [3:0] phases,
  output bmc_pkg::bmc_cmd_t cmd
);
  always_comb begin
    if (phases <= bmc_pkg::SHORT_READ_PHASES) begin
      cmd = bmc_pkg::BMC_CMD_READ;
    end else begin
      unique case (bmc_pkg::bmc_rdsel_t'(rdsel))
        bmc_pkg::BMC_RD_LINE: cmd = bmc_pkg::BMC_CMD_READ_LINE;
        bmc_pkg::BMC_RD_PLAIN: cmd = bmc_pkg::BMC_CMD_READ;
        bmc_pkg::BMC_RD_MULTI: cmd = bmc_pkg::BMC_CMD_READ_MULTI;
        // Reserved code falls back to the reset behaviour
        bmc_pkg::BMC_RD_RSVD: cmd = bmc_pkg::BMC_CMD_READ_MULTI;
      endcase
    end
  end
endmodule : bmc_cmd_sel

// ### verification/bmc_misc_config_sva.sv
/* Checker for the misc host config bank, bound to bmc_misc_config.
   Assumes one clock domain and SYS_RST synchronous, active high. */
`timescale 1ns/1ps
module bmc_misc_config_chk (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire [7:0] CFG_ADDR,
  input wire [31:0] CFG_RDATA,
  input wire CFG_RVALID,
  input wire [2:0] PM_VERSION,
  input wire INT_PENDING_UNMASKED,
  input wire MASTER_INTERRUPT_ENABLE,
  input wire PM_EVENT,
  input wire LINK_ACC,
  input wire LINK_CLK_ACTIVE,
  input wire LINK_TARGET_ABORT,
  input wire LINK_DATA_FORCE,
  input wire [31:0] LINK_FORCE_DATA,
  input wire MST_RD_REQ,
  input wire [3:0] MST_RD_PHASES,
  input wire [1:0] MST_RD_CMD
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  logic [7:0] addr_q;
  // Address of the read whose data shows this cycle
  always_ff @(posedge CLK_SYS) addr_q <= CFG_ADDR;
  wire f0_read = CFG_RVALID && addr_q == 8'hf0;
  AST_RSVD_ZERO: assert property (
    f0_read |-> CFG_RDATA[6:5] == 2'b00) else $error("reserved bits set");
  AST_PMVER_READ: assert property (
    f0_read |-> PM_VERSION == {2'b01, CFG_RDATA[7]})
    else $error("version mismatch");
  AST_ABORT_CAUSE: assert property (
    LINK_TARGET_ABORT || LINK_DATA_FORCE |-> $past(LINK_ACC)
    && !$past(LINK_CLK_ACTIVE)) else $error("answer without cause");
  AST_ABORT_EITHER: assert property (
    LINK_ACC && !LINK_CLK_ACTIVE |=> LINK_TARGET_ABORT ^ LINK_DATA_FORCE)
    else $error("not exactly one answer");
  AST_FORCE_ONES: assert property (
    LINK_DATA_FORCE |-> LINK_FORCE_DATA == 32'hffff_ffff)
    else $error("forced data not all ones");
  AST_SHORT_READ: assert property (
    MST_RD_REQ && MST_RD_PHASES <= 4'h2 |=> MST_RD_CMD == 2'b00)
    else $error("short read not plain");
  AST_CMD_LEGAL: assert property (
    MST_RD_CMD != 2'b11) else $error("illegal command");
  AST_EVENT_ENABLED: assert property (
    INT_PENDING_UNMASKED && MASTER_INTERRUPT_ENABLE |=> PM_EVENT)
    else $error("event missing");
  AST_EVENT_CAUSE: assert property (
    !INT_PENDING_UNMASKED |=> !PM_EVENT) else $error("event without cause");
endmodule : bmc_misc_config_chk

bind bmc_misc_config bmc_misc_config_chk i_bmc_misc_config_chk (.CLK_SYS,
  .SYS_RST, .CFG_ADDR, .CFG_RDATA, .CFG_RVALID, .PM_VERSION,
  .INT_PENDING_UNMASKED, .MASTER_INTERRUPT_ENABLE, .PM_EVENT, .LINK_ACC,
  .LINK_CLK_ACTIVE, .LINK_TARGET_ABORT, .LINK_DATA_FORCE, .LINK_FORCE_DATA,
  .MST_RD_REQ, .MST_RD_PHASES, .MST_RD_CMD);

// ### verification/test_bmc_misc_config.sv
/* Self-checking bench for the misc host config bank.
   Assumes the checker file is compiled alongside; inputs move at negedge. */
`timescale 1ns/1ps
module test_bmc_misc_config;
  logic CLK_SYS = 0, SYS_RST = 1, GLOBAL_RESET_INPUT_N = 1;
  logic LINK_FUND_RESET_N = 1, CFG_SEL = 0, CFG_WR = 0, VID_READ_IN = 0;
  logic INT_PENDING_UNMASKED = 0, MASTER_INTERRUPT_ENABLE = 0, LINK_ACC = 0;
  logic LINK_CLK_ACTIVE = 1, MST_RD_REQ = 0, CFG_RVALID, VID_BIT26, PM_EVENT;
  logic [7:0] CFG_ADDR = 8'hf0;
  logic [3:0] CFG_BYTE_EN = 4'hf, MST_RD_PHASES = 4'h1;
  logic [31:0] CFG_WDATA = 32'h0, CFG_RDATA, LINK_FORCE_DATA, q;
  logic LINK_TARGET_ABORT, LINK_DATA_FORCE, PHY_AUTO_GATE_EN;
  logic HOST_AUTO_GATE_EN, SERIAL_BUS_ENABLE_UNUSED, KEEP_CLOCK_UNUSED;
  logic [2:0] PM_VERSION;
  logic [1:0] MST_RD_CMD;
  int n_errors = 0, comparisons = 0, cycles = 0;
  always #10 CLK_SYS = ~CLK_SYS;
  bmc_misc_config i_bmc_misc_config (.CLK_SYS, .SYS_RST,
    .GLOBAL_RESET_INPUT_N, .LINK_FUND_RESET_N, .CFG_SEL, .CFG_WR, .CFG_ADDR,
    .CFG_BYTE_EN, .CFG_WDATA, .CFG_RDATA, .CFG_RVALID, .VID_READ_IN,
    .VID_BIT26, .PM_VERSION, .INT_PENDING_UNMASKED, .MASTER_INTERRUPT_ENABLE,
    .PM_EVENT, .LINK_ACC, .LINK_CLK_ACTIVE, .LINK_TARGET_ABORT,
    .LINK_DATA_FORCE, .LINK_FORCE_DATA, .MST_RD_REQ, .MST_RD_PHASES,
    .MST_RD_CMD, .PHY_AUTO_GATE_EN, .HOST_AUTO_GATE_EN,
    .SERIAL_BUS_ENABLE_UNUSED, .KEEP_CLOCK_UNUSED);
  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask : cyc
  // One access; read data stands only in the cycle after the request
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
    CFG_SEL = 1; CFG_WR = wr; CFG_ADDR = a; CFG_WDATA = d;
    cyc(1); q = CFG_RDATA;
    chk("rvalid", !wr, CFG_RVALID);
    CFG_SEL = 0; cyc(1);
  endtask : cfg
  task automatic t_write;
    cfg(0, 8'hf0, 0); chk("reset value", 32'h0000_0a90, q);
    chk("pm version", 3'h3, PM_VERSION);
    cfg(1, 8'hf0, 32'hffff_ffff); VID_READ_IN = 1; cyc(1);
    cfg(0, 8'hf0, 0); chk("all set", 32'h0000_0f9f, q);
    chk("vid bit", 1, VID_BIT26);
    chk("phy gate", 0, PHY_AUTO_GATE_EN);
    chk("host gate", 0, HOST_AUTO_GATE_EN);
    cfg(0, 8'h44, 0); chk("unmapped", 0, q);
    cfg(1, 8'hf0, 0); cyc(1);
    chk("vid clear", 0, VID_BIT26);
    chk("pm version 11", 3'h2, PM_VERSION);
    chk("phy gate on", 1, PHY_AUTO_GATE_EN);
    chk("host gate on", 1, HOST_AUTO_GATE_EN);
  endtask : t_write
  task automatic t_link;
    LINK_ACC = 1; LINK_CLK_ACTIVE = 0; cyc(1);
    chk("abort", 1, LINK_TARGET_ABORT);
    cfg(1, 8'hf0, 32'h10); cyc(1);
    chk("force", 1, LINK_DATA_FORCE);
    chk("no abort", 0, LINK_TARGET_ABORT);
    chk("ones", 32'hffff_ffff, LINK_FORCE_DATA);
    LINK_CLK_ACTIVE = 1; cyc(1);
    chk("clocked", 0, {LINK_TARGET_ABORT, LINK_DATA_FORCE});
    LINK_ACC = 0;
  endtask : t_link
  task automatic t_event;
    INT_PENDING_UNMASKED = 1; cyc(1);
    chk("masked event", 0, PM_EVENT);
    cfg(1, 8'hf0, 32'h410); cyc(1);
    chk("override event", 1, PM_EVENT);
    INT_PENDING_UNMASKED = 0;
  endtask : t_event
  task automatic t_cmd;
    logic [1:0] e;
    for (int c = 0; c < 4; c++) begin
      cfg(1, 8'hf0, 32'(c) << 8); cyc(1);
      for (int p = 2; p < 6; p += 3) begin
        MST_RD_REQ = 1; MST_RD_PHASES = 4'(p); cyc(1); MST_RD_REQ = 0;
        cyc(1);
        e = (p <= 2 || c == 1) ? 2'h0 : (c == 0) ? 2'h1 : 2'h2;
        chk("read command", e, MST_RD_CMD);
      end
    end
  endtask : t_cmd
  task automatic t_reset;
    cfg(1, 8'hf0, 0); CFG_BYTE_EN = 4'h2;
    cfg(1, 8'hf0, 32'hffff_ffff); CFG_BYTE_EN = 4'hf;
    cfg(0, 8'hf0, 0); chk("lane one", 32'h0000_0f00, q);
    GLOBAL_RESET_INPUT_N = 0; cyc(1); GLOBAL_RESET_INPUT_N = 1;
    cfg(0, 8'hf0, 0); chk("global reset", 32'h0000_0e90, q);
    cfg(1, 8'hf0, 32'h0000_0403);
    LINK_FUND_RESET_N = 0; cyc(1); LINK_FUND_RESET_N = 1;
    cfg(0, 8'hf0, 0); chk("link reset", 32'h0000_0e90, q);
    SYS_RST = 1; cyc(1); SYS_RST = 0;
    cfg(0, 8'hf0, 0); chk("power on reset", 32'h0000_0a90, q);
  endtask : t_reset
  task automatic give_verdict;
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Whole run needs about 76 cycles; the ceiling leaves ample room
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    cyc(10); SYS_RST = 0;
    t_write(); t_link(); t_event(); t_cmd(); t_reset();
    give_verdict();
  end
endmodule : test_bmc_misc_config
